// ===== design/cictag_top.sv
// apb slave with interrupt code register and message buffer words six and seven
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "cictag_cfg.svh"

module cictag_top
  import cictag_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic store_valid,
  input wire cictag_bufidx_type store_buf,
  input wire cictag_tag_type store_filter,
  input wire logic [7:0] store_byte6,
  input wire logic [7:0] store_byte7,
  input wire logic ev_error,
  input wire logic ev_wake,
  input wire logic ev_overflow,
  input wire logic ev_almost_full,
  output logic irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam int NB = `CICTAG_NUM_BUF;
  localparam int NS = `CICTAG_EV_RX0 + NB;
  logic [15:0] word6_mem [NB];
  cictag_tag_type tag_mem [NB];
  logic [NB-1:0] rxcfg_r;
  logic [NS-1:0] stat_r;
  logic [NS-1:0] mask_r;
  cictag_tag_type last_hit_r;
  logic [NS-1:0] ev_vec;
  logic [NS-1:0] pend;
  cictag_code_type code_nxt;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata_nxt;
  logic err_nxt;

  // buffer index decode, used by read and write paths
  function automatic logic is_buf(input logic [11:0] a);
    is_buf = (a >= `CICTAG_OFF_BUF) && (a < `CICTAG_OFF_BUF + 12'(NB * 8)) && (a[1:0] == 2'b00);
  endfunction

  function automatic cictag_bufidx_type buf_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - `CICTAG_OFF_BUF;
    buf_idx = d[6:3];
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  // event vector: error, wake, overflow, almost full and enabled receive buffer stores
  always_comb begin
    ev_vec = '0;
    ev_vec[`CICTAG_EV_ERR] = ev_error;
    ev_vec[`CICTAG_EV_WAKE] = ev_wake;
    ev_vec[`CICTAG_EV_OVF] = ev_overflow;
    ev_vec[`CICTAG_EV_FULL] = ev_almost_full;
    if (store_valid && rxcfg_r[store_buf]) begin
      ev_vec[`CICTAG_EV_RX0 + int'(store_buf)] = 1'b1;
    end
  end

  // ----------------------------------------
  // message buffer words
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_buf
      // word six: software write or received payload, no reset
      always_ff @(posedge pclk) begin
        if (wr_en && is_buf(paddr) && buf_idx(paddr) == gi && paddr[2] == 1'b0) begin
          if (pstrb[1]) begin
            word6_mem[gi][15:8] <= pwdata[15:8];
          end
          if (pstrb[0]) begin
            word6_mem[gi][7:0] <= pwdata[7:0];
          end
        end else if (store_valid && rxcfg_r[gi] && store_buf == gi) begin
          word6_mem[gi] <= {store_byte7, store_byte6};
        end
      end
      // word seven tag: hardware hit on receive buffers beats software write
      always_ff @(posedge pclk) begin
        if (store_valid && rxcfg_r[gi] && store_buf == gi) begin
          tag_mem[gi] <= store_filter;
        end else if (wr_en && is_buf(paddr) && buf_idx(paddr) == gi && paddr[2] && pstrb[1]) begin
          tag_mem[gi] <= pwdata[`CICTAG_TAG_MSB:`CICTAG_TAG_LSB];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control and interrupt registers
  // ----------------------------------------
  // receive configuration per buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxcfg_r <= '0;
    end else if (wr_en && paddr == `CICTAG_OFF_RXCFG) begin
      rxcfg_r <= pwdata[NB-1:0];
    end
  end

  // mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else if (wr_en && paddr == `CICTAG_OFF_MASK) begin
      mask_r <= pwdata[NS-1:0];
    end
  end

  // sticky status, set beats write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else if (wr_en && paddr == `CICTAG_OFF_STAT) begin
      stat_r <= (stat_r & ~pwdata[NS-1:0]) | ev_vec;
    end else begin
      stat_r <= stat_r | ev_vec;
    end
  end

  // last filter that caused a store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_hit_r <= '0;
    end else if (store_valid && rxcfg_r[store_buf]) begin
      last_hit_r <= store_filter;
    end
  end

  assign pend = stat_r & mask_r;
  assign irq = |pend;

  // priority: error, wake, overflow, almost full, then buffers low first
  always_comb begin
    code_nxt = `CICTAG_CODE_NONE;
    for (int i = NB - 1; i >= 0; i--) begin
      if (pend[`CICTAG_EV_RX0 + i]) begin
        code_nxt = 7'(i);
      end
    end
    if (pend[`CICTAG_EV_FULL]) begin
      code_nxt = `CICTAG_CODE_FULL;
    end
    if (pend[`CICTAG_EV_OVF]) begin
      code_nxt = `CICTAG_CODE_OVF;
    end
    if (pend[`CICTAG_EV_WAKE]) begin
      code_nxt = `CICTAG_CODE_WAKE;
    end
    if (pend[`CICTAG_EV_ERR]) begin
      code_nxt = `CICTAG_CODE_ERR;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // read mux, unused bits zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == `CICTAG_OFF_CODE) begin
      rdata_nxt[15:0] = {3'b000, last_hit_r, 1'b0, code_nxt};
    end else if (paddr == `CICTAG_OFF_STAT) begin
      rdata_nxt[NS-1:0] = stat_r;
    end else if (paddr == `CICTAG_OFF_MASK) begin
      rdata_nxt[NS-1:0] = mask_r;
    end else if (paddr == `CICTAG_OFF_RXCFG) begin
      rdata_nxt[NB-1:0] = rxcfg_r;
    end else if (is_buf(paddr)) begin
      if (paddr[2]) begin
        rdata_nxt[15:0] = {3'b000, tag_mem[buf_idx(paddr)], 8'h00};
      end else begin
        rdata_nxt[15:0] = word6_mem[buf_idx(paddr)];
      end
    end else begin
      err_nxt = 1'b1;
    end
  end

  // registered read data and error for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= err_nxt;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule
`default_nettype wire

// ===== design/cictag_cfg.svh
// constants for the interrupt code and receive buffer tag block
`ifndef CICTAG_CFG_SVH
`define CICTAG_CFG_SVH

`define CICTAG_NUM_BUF 16
`define CICTAG_OFF_CODE 12'h000
`define CICTAG_OFF_STAT 12'h004
`define CICTAG_OFF_MASK 12'h008
`define CICTAG_OFF_RXCFG 12'h00C
`define CICTAG_OFF_BUF 12'h100
`define CICTAG_BUF_STRIDE 12'h008
`define CICTAG_CODE_NONE 7'h40
`define CICTAG_CODE_ERR 7'h41
`define CICTAG_CODE_WAKE 7'h42
`define CICTAG_CODE_OVF 7'h43
`define CICTAG_CODE_FULL 7'h44
`define CICTAG_TAG_LSB 8
`define CICTAG_TAG_MSB 12
`define CICTAG_EV_ERR 0
`define CICTAG_EV_WAKE 1
`define CICTAG_EV_OVF 2
`define CICTAG_EV_FULL 3
`define CICTAG_EV_RX0 4

`endif

// ===== design/cictag_pkg.sv
// types for the interrupt code and receive buffer tag block
package cictag_pkg;
  typedef logic [6:0] cictag_code_type;
  typedef logic [4:0] cictag_tag_type;
  typedef logic [3:0] cictag_bufidx_type;
endpackage

// ===== tb/cictag_top_assertions.sv
// checker for code register and word seven read values
`timescale 1ns/1ps
`default_nettype none
module cictag_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // read access phases of the code register and of word seven
  wire logic acc = psel && penable && !pwrite;
  wire logic rdc = acc && paddr == 12'h000;
  wire logic rd7 = acc && paddr[11:8] == 4'h1 && paddr[2];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_code_valid: assert property (rdc |-> prdata[6:0] < 7'h10 || prdata[6:0] inside {[7'h40:7'h44]})
    else $error("code out of range");
  a_code_zeros: assert property (rdc |-> prdata[31:13] == 19'h0 && !prdata[7])
    else $error("code unused bits set");
  a_filt_range: assert property (rdc |-> !prdata[12])
    else $error("filter number above 15");
  a_word7_zeros: assert property (rd7 |-> prdata[31:13] == 19'h0 && prdata[7:0] == 8'h0)
    else $error("word seven unused bits set");
  a_read_stands: assert property (acc |=> $stable(prdata))
    else $error("read data moved");
  a_wait_free: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  a_unmapped_err: assert property (acc && paddr[11:4] == 8'h01 |-> pslverr)
    else $error("unmapped read without error");
  c_err_code: cover property (rdc && prdata[6:0] == 7'h41);
  c_tag_seen: cover property (rd7 && prdata[12:8] != 5'h0);
  c_idle_code: cover property (rdc && prdata[6:0] == 7'h40);
endmodule
bind cictag_top cictag_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ===== tb/cictag_frame_src.sv
// model of the receive path feeding stores and events
`timescale 1ns/1ps
`default_nettype none
module cictag_frame_src
  import cictag_pkg::*;
(
  input wire logic pclk,
  output logic store_valid,
  output cictag_bufidx_type store_buf,
  output cictag_tag_type store_filter,
  output logic [15:0] sd,
  output logic [3:0] ev
);
  // idle levels at time zero
  initial begin
    store_valid = 1'b0;
    store_buf = 4'h0;
    store_filter = 5'h0;
    sd = 16'h0;
    ev = 4'h0;
  end
  // one-cycle store, then scrambled fields
  task store(input cictag_bufidx_type b, input cictag_tag_type f, input logic [15:0] d);
    @(posedge pclk);
    store_valid <= 1'b1;
    store_buf <= b;
    store_filter <= f;
    sd <= d;
    @(posedge pclk);
    store_valid <= 1'b0;
    store_buf <= ~b;
    store_filter <= ~f;
    sd <= ~d;
  endtask
  // one-cycle event pulses
  task pulse(input logic [3:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 4'h0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_cictag_top.sv
// testbench for the interrupt code and buffer tag block
`timescale 1ns/1ps
`default_nettype none
module tb_cictag_top;
  import cictag_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hF, ev;
  logic [15:0] sd;
  logic pready, pslverr, irq, store_valid;
  cictag_bufidx_type store_buf;
  cictag_tag_type store_filter;
  int bad_count = 0, check_count = 0;
  cictag_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .store_valid, .store_buf, .store_filter, .store_byte6(sd[7:0]), .store_byte7(sd[15:8]),
    .ev_error(ev[0]), .ev_wake(ev[1]), .ev_overflow(ev[2]), .ev_almost_full(ev[3]), .irq);
  cictag_frame_src u_src (.pclk, .store_valid, .store_buf, .store_filter, .sd, .ev);
  // clock
  initial begin
    forever #4 pclk = ~pclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (2000) @(posedge pclk);
    bad_count++;
    complete_run;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h40);
    xfer(1'b1, 12'h00C, 32'h1);
    xfer(1'b1, 12'h100, 32'hA55A);
    rd(12'h100, 32'hA55A);
    xfer(1'b1, 12'h10C, 32'hFFFF);
    rd(12'h10C, 32'h1F00);
    u_src.store(4'h0, 5'h05, 16'h3412);
    u_src.store(4'h1, 5'h09, 16'h7788);
    rd(12'h100, 32'h3412);
    rd(12'h104, 32'h0500);
    rd(12'h10C, 32'h1F00);
    rd(12'h000, 32'h0540);
    xfer(1'b1, 12'h008, 32'hF);
    u_src.pulse(4'h3);
    rd(12'h000, 32'h0541);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h004, 32'h1);
    rd(12'h000, 32'h0542);
    xfer(1'b1, 12'h004, 32'h2);
    chk({31'h0, irq}, 32'h0);
    u_src.pulse(4'hC);
    rd(12'h000, 32'h0543);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, 12'h004, 32'h4);
    rd(12'h000, 32'h0544);
    xfer(1'b1, 12'h004, 32'h18);
    rd(12'h000, 32'h0540);
    xfer(1'b1, 12'h008, 32'h10);
    u_src.store(4'h0, 5'h0F, 16'h0102);
    rd(12'h000, 32'h0F00);
    rd(12'h010, 32'h0);
    chk({31'h0, pslverr}, 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
